// [logic/ihw_pkg.sv]
// Purpose: Shared constants for the system-health watchdog block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package ihw_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STS1 = 8'h04;
  localparam logic [7:0] OFS_STS2 = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0C;
  localparam logic [7:0] OFS_KICK = 8'h10;
  localparam logic [7:0] OFS_ERRSEL = 8'h14;
  localparam logic [7:0] OFS_MSG = 8'h18;
  localparam logic [7:0] OFS_MSGACK = 8'h1C;
  // Control register fields
  localparam int unsigned CTL_WD_EN = 0;
  localparam int unsigned CTL_ACT_LO = 1;
  localparam int unsigned CTL_SLEEP = 3;
  localparam int unsigned CTL_HALT = 4;
  // Status register 1 fields
  localparam int unsigned S1_FIRST = 0;
  localparam int unsigned S1_SECOND = 1;
  localparam int unsigned S1_ERR = 2;
  // Status register 2 fields
  localparam int unsigned S2_CASE = 0;
  localparam int unsigned S2_BOOT = 1;
  // Case-open action encodings
  localparam logic [1:0] ACT_NONE = 2'b00;
  localparam logic [1:0] ACT_HEALTH = 2'b01;
  localparam logic [1:0] ACT_MGMT = 2'b10;
  // Error routing field positions
  localparam int unsigned ERR_MGMT = 0;
  localparam int unsigned ERR_CTRL = 1;
  localparam int unsigned ERR_SYS = 2;
  localparam int unsigned ERR_HLTH = 3;
  // Reset values and timing
  localparam logic [15:0] RELOAD_RST = 16'h0004;
  localparam int unsigned SECOND_TICKS = 4;
  localparam int unsigned DEBOUNCE_PERIODS = 2;
  localparam int unsigned TICK_DIV = 200;
  // Message event codes
  localparam logic [3:0] EV_CASE = 4'h1;
  localparam logic [3:0] EV_WDOG = 4'h2;
  localparam logic [3:0] EV_ALERT = 4'h3;
  localparam logic [3:0] EV_BATT = 4'h4;
  localparam logic [3:0] EV_PWR = 4'h5;
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_FIRST = 2'b01,
    WD_SECOND = 2'b10,
    WD_DONE = 2'b11
  } ihw_wd_t;
endpackage

// [logic/ihw_debounce.sv]
// Purpose: Debounce of case-open input on the real-time-clock tick
// Assumes: rtc_tick is a one-cycle pulse per real-time-clock period
// Notes: Output changes only after PERIODS stable samples
`timescale 1ns/100ps
module ihw_debounce #(
  parameter int unsigned PERIODS = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rtc_tick,
  input wire logic raw_in,
  output logic clean_out
);
  logic s1_reg;
  logic s2_reg;
  logic [3:0] cnt_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
    end
  end

  // Stable-level counter across consecutive samples [RULE5] [RULE14]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      clean_out <= 1'b0;
    end else if (s2_reg == clean_out) begin
      cnt_reg <= 4'h0;
    end else if (rtc_tick) begin
      if (cnt_reg == 4'(PERIODS - 1)) begin
        clean_out <= s2_reg;
        cnt_reg <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule // ihw_debounce

// [logic/ihw_top.sv]
// Purpose: System-health logic: two-stage watchdog, case-open detect,
//   error routing and event messages toward an external LAN controller
// Assumes: APB slave, single clock, real-time-clock tick derived inside
// Notes:
// Functional notes
// RULE1: First watchdog timeout raises a management interrupt.
// RULE2: Second fixed timer runs only after first timeout, then resets.
// RULE3: A strap input suppresses the second-timeout reset.
// RULE4: Host errors may raise any of the four interrupt outputs.
// RULE5: The case-open input is debounced over two real-time-clock periods.
// RULE6: Debounced case-open activation sets the case-open flag.
// RULE7: An action-select field picks management or health interrupt.
// RULE8: Writing the sleep-entry trigger requests soft-off sleep.
// RULE9: After clearing, the flag reads the live case-open level.
// RULE10: Once written with one, the flag falls when the input deactivates.
// RULE11: Compatible mode uses only the host bus; extra controllers off.
// RULE12: Event messages go out via the host bus to a LAN controller.
// RULE13: Messages on assertion of all five events, deassertion of two.
// RULE14: Debounce uses a stable-level counter before updating flags.
`timescale 1ns/100ps
module ihw_top #(
  parameter int unsigned TICK_DIV = ihw_pkg::TICK_DIV
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic case_open_n,
  input wire logic smbalert_n,
  input wire logic battery_low_input_n,
  input wire logic power_failure_event,
  input wire logic host_error,
  input wire logic no_reboot_strap,
  input wire logic advanced_mode_strap,
  output logic management_interrupt,
  output logic control_interrupt,
  output logic system_error,
  output logic health_interrupt,
  output logic system_reset_req,
  output logic sleep_soft_off_req,
  output logic mgmt_bus_ctrl_en,
  output logic msg_valid,
  output logic [3:0] msg_code,
  output logic msg_assert
);
  logic r1_reg;
  logic rst_n;
  logic [7:0] tick_cnt_reg;
  logic rtc_tick;
  logic case_clean;
  logic case_prev_reg;
  logic [7:0] health_control_reg;
  logic [15:0] reload_reg;
  logic [3:0] errsel_reg;
  logic [2:0] sts1_reg;
  logic case_open_flag;
  logic case_armed_reg;
  logic boot_reg;
  logic noreboot_reg;
  logic strap_done_reg;
  ihw_pkg::ihw_wd_t wd_reg;
  logic [15:0] wd_cnt_reg;
  logic wr;
  logic rd_access;
  logic kick;
  logic first_evt;
  logic second_evt;
  logic alert_prev_reg;
  logic batt_prev_reg;
  logic pwr_prev_reg;
  logic [4:0] pend_reg;
  logic [4:0] pend_set;
  logic [1:0] dir_reg;
  logic case_rise;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      r1_reg <= 1'b1;
      rst_n <= r1_reg;
    end
  end

  // Real-time-clock tick divider
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 8'h00;
    end else if (tick_cnt_reg == 8'(TICK_DIV - 1)) begin
      tick_cnt_reg <= 8'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end
  assign rtc_tick = (tick_cnt_reg == 8'(TICK_DIV - 1));

  ihw_debounce #(
    .PERIODS(ihw_pkg::DEBOUNCE_PERIODS)
  ) u_deb (
    .clock(clock),
    .rst_n(rst_n),
    .rtc_tick(rtc_tick),
    .raw_in(~case_open_n),
    .clean_out(case_clean)
  );

  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign kick = wr && (paddr == ihw_pkg::OFS_KICK);
  always_comb begin
    case (paddr)
      ihw_pkg::OFS_CTRL, ihw_pkg::OFS_STS1, ihw_pkg::OFS_STS2,
      ihw_pkg::OFS_RELOAD, ihw_pkg::OFS_KICK, ihw_pkg::OFS_ERRSEL,
      ihw_pkg::OFS_MSG, ihw_pkg::OFS_MSGACK: pslverr = 1'b0;
      default: pslverr = psel && penable;
    endcase
  end

  // Strap capture after reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      noreboot_reg <= 1'b0;
      strap_done_reg <= 1'b0;
      mgmt_bus_ctrl_en <= 1'b0;
    end else if (!strap_done_reg) begin
      noreboot_reg <= no_reboot_strap;
      strap_done_reg <= 1'b1;
      mgmt_bus_ctrl_en <= advanced_mode_strap; // [RULE11]
    end
  end

  // Writable configuration
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      health_control_reg <= 8'h00;
      reload_reg <= ihw_pkg::RELOAD_RST;
      errsel_reg <= 4'h0;
    end else if (wr) begin
      if (paddr == ihw_pkg::OFS_CTRL) begin
        health_control_reg <= pwdata[7:0] & 8'h17;
      end
      if (paddr == ihw_pkg::OFS_RELOAD) begin
        reload_reg <= pwdata[15:0];
      end
      if (paddr == ihw_pkg::OFS_ERRSEL) begin
        errsel_reg <= pwdata[3:0];
      end
    end
  end

  // Sleep-entry trigger pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleep_soft_off_req <= 1'b0;
    end else begin
      sleep_soft_off_req <= wr && (paddr == ihw_pkg::OFS_CTRL) &&
        pwdata[ihw_pkg::CTL_SLEEP]; // [RULE8]
    end
  end

  // Two-stage watchdog
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wd_reg <= ihw_pkg::WD_IDLE;
      wd_cnt_reg <= 16'h0000;
    end else if (!health_control_reg[ihw_pkg::CTL_WD_EN] ||
        health_control_reg[ihw_pkg::CTL_HALT]) begin
      wd_reg <= ihw_pkg::WD_IDLE;
      wd_cnt_reg <= reload_reg;
    end else if (kick) begin
      wd_reg <= ihw_pkg::WD_FIRST;
      wd_cnt_reg <= reload_reg;
    end else begin
      case (wd_reg)
        ihw_pkg::WD_IDLE: begin
          wd_reg <= ihw_pkg::WD_FIRST;
          wd_cnt_reg <= reload_reg;
        end
        ihw_pkg::WD_FIRST: begin
          if (rtc_tick) begin
            if (wd_cnt_reg <= 16'h0001) begin
              wd_reg <= ihw_pkg::WD_SECOND; // [RULE2]
              wd_cnt_reg <= 16'(ihw_pkg::SECOND_TICKS);
            end else begin
              wd_cnt_reg <= wd_cnt_reg - 16'h0001;
            end
          end
        end
        ihw_pkg::WD_SECOND: begin
          if (rtc_tick) begin
            if (wd_cnt_reg <= 16'h0001) begin
              wd_reg <= ihw_pkg::WD_DONE;
            end else begin
              wd_cnt_reg <= wd_cnt_reg - 16'h0001;
            end
          end
        end
        ihw_pkg::WD_DONE: wd_reg <= ihw_pkg::WD_DONE;
        default: wd_reg <= ihw_pkg::WD_IDLE;
      endcase
    end
  end
  assign first_evt = (wd_reg == ihw_pkg::WD_FIRST) && rtc_tick &&
    (wd_cnt_reg <= 16'h0001) && !kick &&
    health_control_reg[ihw_pkg::CTL_WD_EN] &&
    !health_control_reg[ihw_pkg::CTL_HALT];
  assign second_evt = (wd_reg == ihw_pkg::WD_SECOND) && rtc_tick &&
    (wd_cnt_reg <= 16'h0001) && !kick &&
    health_control_reg[ihw_pkg::CTL_WD_EN] &&
    !health_control_reg[ihw_pkg::CTL_HALT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      system_reset_req <= 1'b0;
    end else begin
      system_reset_req <= second_evt && !noreboot_reg; // [RULE3]
    end
  end

  // Status 1: write one to clear; set wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sts1_reg <= 3'b000;
    end else begin
      if (wr && paddr == ihw_pkg::OFS_STS1) begin
        sts1_reg <= sts1_reg & ~pwdata[2:0] |
          {host_error, second_evt, first_evt};
      end else begin
        sts1_reg <= sts1_reg | {host_error, second_evt, first_evt};
      end
    end
  end

  // Case-open flag with clear-to-level behaviour
  assign case_rise = case_clean && !case_prev_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      case_prev_reg <= 1'b0;
      case_open_flag <= 1'b0;
      case_armed_reg <= 1'b0;
      boot_reg <= 1'b0;
    end else begin
      case_prev_reg <= case_clean;
      if (second_evt) begin
        boot_reg <= 1'b1;
      end else if (wr && paddr == ihw_pkg::OFS_STS2 &&
          pwdata[ihw_pkg::S2_BOOT]) begin
        boot_reg <= 1'b0;
      end
      if (case_rise) begin
        case_open_flag <= 1'b1; // [RULE6]
        case_armed_reg <= 1'b0;
      end else if (wr && paddr == ihw_pkg::OFS_STS2 &&
          pwdata[ihw_pkg::S2_CASE]) begin
        case_armed_reg <= 1'b1;
        case_open_flag <= case_clean; // [RULE9]
      end else if (case_armed_reg) begin
        case_open_flag <= case_clean; // [RULE10]
      end
    end
  end

  // Interrupt routing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      management_interrupt <= 1'b0;
      control_interrupt <= 1'b0;
      system_error <= 1'b0;
      health_interrupt <= 1'b0;
    end else begin
      management_interrupt <= sts1_reg[ihw_pkg::S1_FIRST] || // [RULE1]
        (sts1_reg[ihw_pkg::S1_ERR] && errsel_reg[ihw_pkg::ERR_MGMT]) ||
        (case_open_flag && health_control_reg[2:1] ==
          ihw_pkg::ACT_MGMT); // [RULE7]
      control_interrupt <= sts1_reg[ihw_pkg::S1_ERR] &&
        errsel_reg[ihw_pkg::ERR_CTRL]; // [RULE4]
      system_error <= sts1_reg[ihw_pkg::S1_ERR] &&
        errsel_reg[ihw_pkg::ERR_SYS];
      health_interrupt <= (sts1_reg[ihw_pkg::S1_ERR] &&
        errsel_reg[ihw_pkg::ERR_HLTH]) ||
        (case_open_flag && health_control_reg[2:1] ==
          ihw_pkg::ACT_HEALTH); // [RULE7]
    end
  end

  // Event message queue toward LAN controller
  assign pend_set = {
    pwr_prev_reg ^ power_failure_event ? power_failure_event : 1'b0,
    batt_prev_reg ^ ~battery_low_input_n,
    alert_prev_reg ^ ~smbalert_n,
    first_evt,
    case_rise
  }; // [RULE13]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alert_prev_reg <= 1'b0;
      batt_prev_reg <= 1'b0;
      pwr_prev_reg <= 1'b0;
      pend_reg <= 5'b00000;
      dir_reg <= 2'b00;
    end else begin
      alert_prev_reg <= ~smbalert_n;
      batt_prev_reg <= ~battery_low_input_n;
      pwr_prev_reg <= power_failure_event;
      if (pend_set[2]) begin
        dir_reg[0] <= ~smbalert_n;
      end
      if (pend_set[3]) begin
        dir_reg[1] <= ~battery_low_input_n;
      end
      if (wr && paddr == ihw_pkg::OFS_MSGACK) begin
        pend_reg <= pend_reg & ~pwdata[4:0] | pend_set; // [RULE12]
      end else begin
        pend_reg <= pend_reg | pend_set;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      msg_valid <= 1'b0;
      msg_code <= 4'h0;
      msg_assert <= 1'b0;
    end else begin
      msg_valid <= |pend_reg;
      msg_assert <= 1'b1;
      if (pend_reg[0]) begin
        msg_code <= ihw_pkg::EV_CASE;
      end else if (pend_reg[1]) begin
        msg_code <= ihw_pkg::EV_WDOG;
      end else if (pend_reg[2]) begin
        msg_code <= ihw_pkg::EV_ALERT;
        msg_assert <= dir_reg[0];
      end else if (pend_reg[3]) begin
        msg_code <= ihw_pkg::EV_BATT;
        msg_assert <= dir_reg[1];
      end else if (pend_reg[4]) begin
        msg_code <= ihw_pkg::EV_PWR;
      end else begin
        msg_code <= 4'h0;
      end
    end
  end

  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_access) begin
      case (paddr)
        ihw_pkg::OFS_CTRL: prdata = {24'h00_0000, health_control_reg};
        ihw_pkg::OFS_STS1: prdata = {27'h000_0000, wd_reg, sts1_reg};
        ihw_pkg::OFS_STS2: prdata = {30'h0000_0000, boot_reg,
          case_open_flag};
        ihw_pkg::OFS_RELOAD: prdata = {16'h0000, reload_reg};
        ihw_pkg::OFS_KICK: prdata = {16'h0000, wd_cnt_reg};
        ihw_pkg::OFS_ERRSEL: prdata = {28'h000_0000, errsel_reg};
        ihw_pkg::OFS_MSG: prdata = {25'h000_0000, dir_reg, pend_reg};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule // ihw_top

// [tb/ihw_chk.sv]
// Purpose: Port checks for the system-health block
// Assumes: Bound to ihw_top, one clock
// Notes: Control routing bit mirrored from APB writes
`timescale 1ns/100ps
module ihw_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic no_reboot_strap,
  input wire logic advanced_mode_strap,
  input wire logic host_error,
  input wire logic management_interrupt,
  input wire logic control_interrupt,
  input wire logic system_reset_req,
  input wire logic sleep_soft_off_req,
  input wire logic mgmt_bus_ctrl_en,
  input wire logic msg_valid,
  input wire logic [3:0] msg_code,
  input wire logic msg_assert
);
  logic wr;
  logic ack;
  logic ctrl_sel_reg;
  logic mi_seen_reg;
  assign wr = psel && penable && pwrite;
  assign ack = wr && paddr == ihw_pkg::OFS_MSGACK;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_sel_reg <= 1'b0;
    end else if (wr && paddr == ihw_pkg::OFS_ERRSEL) begin
      ctrl_sel_reg <= pwdata[ihw_pkg::ERR_CTRL];
    end
  end
  // Remembers any management interrupt (first stage, routed host error or case-open) even if software cleared it later
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mi_seen_reg <= 1'b0;
    end else if (management_interrupt) begin
      mi_seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  strap_hold_a: assert property (
    no_reboot_strap |-> !system_reset_req)
    else $error("reset request while strap set");
  rst_pulse_a: assert property (
    system_reset_req |=> !system_reset_req)
    else $error("reset request longer than one cycle");
  rst_after_a: assert property (
    system_reset_req |-> mi_seen_reg)
    else $error("reset request without first timeout");
  sleep_req_a: assert property (
    wr && paddr == ihw_pkg::OFS_CTRL && pwdata[ihw_pkg::CTL_SLEEP]
    |-> ##[1:2] sleep_soft_off_req)
    else $error("sleep request missing");
  sleep_one_a: assert property (
    sleep_soft_off_req |=> !sleep_soft_off_req)
    else $error("sleep request longer than one cycle");
  err_ctrl_a: assert property (
    host_error && ctrl_sel_reg |-> ##[1:4] control_interrupt)
    else $error("routed host error gave no control interrupt");
  compat_a: assert property (
    !advanced_mode_strap |-> !mgmt_bus_ctrl_en)
    else $error("extra bus controllers on in compatible mode");
  deass_kind_a: assert property (
    msg_valid && !msg_assert |->
    msg_code == ihw_pkg::EV_ALERT || msg_code == ihw_pkg::EV_BATT)
    else $error("deassertion message for wrong event");
  msg_hold_a: assert property (
    $fell(msg_valid) |-> $past(ack) || $past(ack, 2))
    else $error("message dropped without acknowledge");
  cover property (system_reset_req);
  cover property (sleep_soft_off_req);
  cover property (msg_valid && !msg_assert);
endmodule // ihw_chk
bind ihw_top ihw_chk u_chk (.*);

// [tb/ihw_lan_model.sv]
// Purpose: External LAN controller taking event messages
// Assumes: Message held until software acknowledges it
// Notes: Records the newest message and a count
`timescale 1ns/100ps
module ihw_lan_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic msg_valid,
  input wire logic [3:0] msg_code,
  input wire logic msg_assert,
  output logic [3:0] last_code,
  output logic last_assert,
  output int msg_count
);
  logic prev_valid;
  logic [3:0] prev_code;
  // New message when valid rises or head changes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_valid <= 1'b0;
      prev_code <= 4'h0;
      last_code <= 4'h0;
      last_assert <= 1'b0;
      msg_count <= 0;
    end else begin
      prev_valid <= msg_valid;
      prev_code <= msg_code;
      if (msg_valid && (!prev_valid || msg_code != prev_code)) begin
        last_code <= msg_code;
        last_assert <= msg_assert;
        msg_count <= msg_count + 1;
      end
    end
  end
endmodule // ihw_lan_model

// [tb/intrusion_watchdog_mgmt_tb_top.sv]
// Purpose: Self-checking bench for the system-health block
// Assumes: TICK_DIV of 4, zero-wait APB
// Notes: Strap changes only while reset is held
`timescale 1ns/100ps
module intrusion_watchdog_mgmt_tb_top;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, rv;
  logic pready, pslverr, er;
  logic case_open_n = 1'b1, smbalert_n = 1'b1;
  logic battery_low_input_n = 1'b1, power_failure_event = 1'b0;
  logic host_error = 1'b0, no_reboot_strap = 1'b0;
  logic advanced_mode_strap = 1'b0;
  logic management_interrupt, control_interrupt, system_error;
  logic health_interrupt, system_reset_req, sleep_soft_off_req;
  logic mgmt_bus_ctrl_en, msg_valid, msg_assert, last_assert;
  logic [3:0] msg_code, last_code;
  logic [1:0] acts [3] = '{2'b00, 2'b01, 2'b10};
  int bad_count = 0, total_checks = 0, rst_seen = 0, slp_seen = 0;
  int seed = 35843, t0, msg_count;
  always #2.5 clock = ~clock;
  ihw_top #(.TICK_DIV(4)) i_dut (.*);
  ihw_lan_model i_lan (.*);
  always @(posedge clock) begin
    if (system_reset_req === 1'b1) rst_seen++;
    if (sleep_soft_off_req === 1'b1) slp_seen++;
  end
  task automatic chk_w(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, g);
    chk_w(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk_b("pready", 1'b1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, v);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while ((rd & m) !== v && k < 60);
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  function automatic logic [31:0] act_exp(logic [1:0] a);
    return {30'h0, a == ihw_pkg::ACT_HEALTH, a == ihw_pkg::ACT_MGMT};
  endfunction
  function automatic logic [31:0] ev_mask(int i);
    return (32'h1 << (2 + i)) | (i < 2 ? 32'h1 << (5 + i) : 32'h0);
  endfunction
  function automatic logic [31:0] ev_exp(int i, int v);
    return v ? 32'h0 : ev_mask(i);
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    do_reset();
    apb(1'b0, ihw_pkg::OFS_CTRL, 32'h0);
    chk_w("ctrl_rst", 32'h0, rd);
    apb(1'b0, ihw_pkg::OFS_RELOAD, 32'h0);
    chk_w("reload_rst", {16'h0, ihw_pkg::RELOAD_RST}, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk_w("unmapped_rd", 32'h0, rd);
    chk_b("unmapped_err", 1'b1, er);
    chk_b("mgmt_bus_en", 1'b0, mgmt_bus_ctrl_en);
    for (int s = 0; s < 2; s++) begin
      no_reboot_strap <= s[0];
      advanced_mode_strap <= s[0];
      do_reset();
      rv = 32'(($random(seed) & 3) + 2);
      apb(1'b1, ihw_pkg::OFS_RELOAD, rv);
      apb(1'b1, ihw_pkg::OFS_CTRL, 32'h1);
      t0 = 0;
      while (management_interrupt !== 1'b1 && t0 < 400) begin
        @(posedge clock);
        t0++;
      end
      chk_b("first_tmo", 1'b1,
            t0 >= (rv - 1) * 4 && t0 <= rv * 4 + 8);
      chk_b("mgmt_bus_en", s[0], mgmt_bus_ctrl_en);
      t0 = rst_seen;
      repeat (10) @(posedge clock);
      chk_w("early_rst", 32'h0, rst_seen - t0);
      repeat (22) @(posedge clock);
      chk_w("rst_pulses", 32'(1 - s), rst_seen - t0);
      apb(1'b0, ihw_pkg::OFS_STS2, 32'h0);
      chk_b("boot_sts", 1'b1, rd[ihw_pkg::S2_BOOT]);
      apb(1'b0, ihw_pkg::OFS_MSG, 32'h0);
      chk_b("wdog_msg", 1'b1, rd[1]);
      chk_w("lan_code", {28'h0, ihw_pkg::EV_WDOG},
            {28'h0, last_code});
    end
    apb(1'b1, ihw_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, ihw_pkg::OFS_STS1, 32'h7);
    apb(1'b1, ihw_pkg::OFS_MSGACK, 32'h1F);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ihw_pkg::OFS_ERRSEL, 32'h1 << k);
      host_error <= 1'b1;
      repeat (6) @(posedge clock);
      chk_w("err_route", 32'h1 << k, {28'h0, health_interrupt, system_error,
            control_interrupt, management_interrupt});
      host_error <= 1'b0;
      apb(1'b1, ihw_pkg::OFS_STS1, 32'h7);
    end
    case_open_n <= 1'b0;
    @(posedge clock);
    case_open_n <= 1'b1;
    repeat (30) @(posedge clock);
    apb(1'b0, ihw_pkg::OFS_STS2, 32'h0);
    chk_b("glitch_flag", 1'b0, rd[0]);
    case_open_n <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, ihw_pkg::OFS_CTRL, 32'(acts[j]) << 1);
      poll(ihw_pkg::OFS_STS2, 32'h1, 32'h1);
      chk_b("case_flag", 1'b1, rd[0]);
      chk_w("case_act", act_exp(acts[j]),
            {30'h0, health_interrupt, management_interrupt});
    end
    apb(1'b0, ihw_pkg::OFS_MSG, 32'h0);
    chk_b("case_msg", 1'b1, rd[0]);
    apb(1'b1, ihw_pkg::OFS_MSGACK, 32'h1F);
    apb(1'b1, ihw_pkg::OFS_STS2, 32'h1);
    apb(1'b0, ihw_pkg::OFS_STS2, 32'h0);
    chk_b("live_level", 1'b1, rd[0]);
    case_open_n <= 1'b1;
    poll(ihw_pkg::OFS_STS2, 32'h1, 32'h0);
    chk_b("flag_fall", 1'b0, rd[0]);
    apb(1'b0, ihw_pkg::OFS_MSG, 32'h0);
    chk_b("no_case_deassert", 1'b0, rd[0]);
    for (int i = 0; i < 3; i++) begin
      for (int v = 0; v < 2; v++) begin
        if (i == 0) smbalert_n <= v[0];
        else if (i == 1) battery_low_input_n <= v[0];
        else power_failure_event <= !v[0];
        repeat (40) @(posedge clock);
        apb(1'b0, ihw_pkg::OFS_MSG, 32'h0);
        chk_w("event_msg", ev_exp(i, v) | (i < 2 ? 32'h1 << (2 + i) : 0),
              rd & ev_mask(i));
        if (i < 2 || v == 0) begin
          chk_w("lan_code", 32'(ihw_pkg::EV_ALERT + i),
                {28'h0, last_code});
          chk_b("lan_dir", !v[0], last_assert);
        end
        apb(1'b1, ihw_pkg::OFS_MSGACK, 32'h1F);
      end
    end
    t0 = slp_seen;
    apb(1'b1, ihw_pkg::OFS_CTRL, 32'h8);
    repeat (4) @(posedge clock);
    chk_w("sleep_pulses", 32'h1, slp_seen - t0);
    apb(1'b0, ihw_pkg::OFS_CTRL, 32'h0);
    chk_b("sleep_rd", 1'b0, rd[ihw_pkg::CTL_SLEEP]);
    // Regular kicks keep the first stage from expiring
    apb(1'b1, ihw_pkg::OFS_CTRL, 32'h1);
    repeat (12) apb(1'b1, ihw_pkg::OFS_KICK, 32'h0);
    chk_b("kick_hold", 1'b0, management_interrupt);
    // Halt holds the watchdog idle and reloaded well past the reload span
    apb(1'b1, ihw_pkg::OFS_CTRL, 32'h11);
    repeat (60) @(posedge clock);
    chk_b("halt_hold", 1'b0, management_interrupt);
    chk_w("lan_count", 32'h0000_0007, msg_count);
    summarize();
  end
endmodule // intrusion_watchdog_mgmt_tb_top
